// File: hw/bas_point_defs.vh
// Constants for the building-automation point command handler
`ifndef BAS_POINT_DEFS_VH
`define BAS_POINT_DEFS_VH
`define CMD_SYS 4'h0
`define CMD_READ 4'h1
`define CMD_WRITE 4'h2
`define CMD_OVR 4'h7
`define SUB_SYNC 4'h0
`define SUB_RDMEM 4'h1
`define SUB_POLL 4'h4
`define SUB_POLL_ACK 4'h5
`define SUB_WARM 4'h8
`define SUB_STATUS 4'h9
`define SUB_OVERRIDE 4'h2
`define SUB_RELEASE 4'h3
`define RGN_AI 4'h1
`define RGN_BI 4'h2
`define RGN_AO 4'h3
`define RGN_BO 4'h4
`define RGN_INT_LO 4'h5
`define RGN_INT_HI 4'h8
`define ERR_NONE 8'h00
`define ERR_CMD 8'h01
`define ERR_ATTR 8'h11
`define AI_ATTR_VAL_HI 8'h03
`define AI_ATTR_LIM_LO 8'h08
`define AI_ATTR_LIM_HI 8'h0c
`define AI_ATTR_MAX 8'h0e
`define BI_ATTR_OK_HI 8'h02
`define AO_ATTR_OK_HI 8'h03
`define BO_ATTR_OK_HI 8'h05
`define ATTR_CONFIG 8'h01
`define KIND_NONE 3'h0
`define KIND_LIMIT_RD 3'h1
`define KIND_STATUS 3'h2
`define KIND_POLL 3'h3
`define KIND_BO_SET 3'h4
`define KIND_AO_SET 3'h5
`define KIND_LIMIT_WR 3'h6
`define BO_RUN_LAST 8'h09
`define BO_RESET 8'h0d
`define BO_UNIV_FIRST 8'h0e
`define BO_UNIV_LAST 8'h12
`define BO_RELAY 8'h13
`define BO_PROTECT 8'h14
`define RUN_RESET_BIT 4'hf
`define UNIV_RELAY_BIT 4'h8
`define AO_FC_READ 8'h0f
`define AO_FC_WRITE 8'h10
`define AO_FC_DATA 8'h11
`define TERM_FN_ACTIVE 8'h1b
`define ASCII_0000 32'h30303030
`define BAUD_RATE 9600
`define CLK_HZ 250000000
`define ADR_RUN_WORD 8'h00
`define ADR_UNIV_WORD 8'h04
`define ADR_PROTECT 8'h08
`define ADR_STATION 8'h0c
`define ADR_FC_READ 8'h10
`define ADR_STATE 8'h14
`define ADR_TERM_BASE 8'h18
`define STATION_RST 8'h01
`endif

// File: hw/ai_limit_mem.v
// Storage for analog-input limit and differential values
`timescale 1ns/1ps
module ai_limit_mem #(
	parameter DW = 32,
	parameter AW = 6
) (
	input wire mclk, // System clock
	input wire wr_en, // Write strobe
	input wire [AW-1:0] wr_addr, // Write address
	input wire [DW-1:0] wr_data, // Write data
	input wire [AW-1:0] rd_addr, // Read address
	output reg [DW-1:0] rd_data_q // Registered read data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// Contents are undefined until written; no reset keeps it a plain RAM
	always @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_q <= mem[rd_addr];
	end
endmodule // ai_limit_mem

// File: hw/cmd_classify.v
// Decides ACK or NAK, error code and action kind for one request
`timescale 1ns/1ps
`include "bas_point_defs.vh"
module cmd_classify (
	input wire [3:0] cmd, // Command code
	input wire [3:0] sub, // Sub-command code
	input wire [3:0] region, // Point region
	input wire [7:0] attr, // Attribute number
	output reg ack, // High for ACK
	output reg [7:0] err, // NAK error code
	output reg [2:0] kind // Action to carry out
);
	// Unknown commands, sub-commands and read regions fall to NAK 01 so the controller sees a clean refusal
	always @* begin
		ack = 1'b0;
		err = `ERR_CMD;
		kind = `KIND_NONE;
		case (cmd)
		`CMD_SYS: begin
			if (sub == `SUB_SYNC) begin
				ack = 1'b1;
			end else if (sub == `SUB_POLL || sub == `SUB_POLL_ACK) begin
				ack = 1'b1;
				kind = `KIND_POLL;
			end else if (sub == `SUB_STATUS) begin
				ack = 1'b1;
				kind = `KIND_STATUS;
			end
			if (sub == `SUB_RDMEM || sub == `SUB_WARM) begin
				ack = 1'b0;
			end
			// An accepted system command carries no error code
			if (ack) begin
				err = `ERR_NONE;
			end
		end
		`CMD_READ: begin
			err = `ERR_ATTR;
			if (region == `RGN_AI) begin
				if (attr != 8'h00 && attr <= `AI_ATTR_VAL_HI) begin
					ack = 1'b1;
				end else if (attr >= `AI_ATTR_LIM_LO && attr <= `AI_ATTR_LIM_HI) begin
					ack = 1'b1;
					kind = `KIND_LIMIT_RD;
				end
			end else if (region == `RGN_BI) begin
				ack = (attr != 8'h00 && attr <= `BI_ATTR_OK_HI);
			end else if (region == `RGN_AO) begin
				ack = (attr != 8'h00 && attr <= `AO_ATTR_OK_HI);
			end else if (region == `RGN_BO) begin
				ack = (attr != 8'h00 && attr <= `BO_ATTR_OK_HI);
			end else begin
				err = `ERR_CMD;
			end
			if (ack) begin
				err = `ERR_NONE;
			end
		end
		`CMD_WRITE: begin
			err = `ERR_ATTR;
			if (region == `RGN_AI) begin
				if (attr == `ATTR_CONFIG) begin
					ack = 1'b1;
				end else if (attr >= `AI_ATTR_LIM_LO && attr <= `AI_ATTR_LIM_HI) begin
					ack = 1'b1;
					kind = `KIND_LIMIT_WR;
				end
			end else if (region == `RGN_BO) begin
				ack = (attr == `ATTR_CONFIG) || (attr >= 8'h03 && attr <= `BO_ATTR_OK_HI);
			end else if (region >= `RGN_BI && region <= `RGN_AO) begin
				ack = (attr == `ATTR_CONFIG);
			end
			if (ack) begin
				err = `ERR_NONE;
			end
		end
		`CMD_OVR: begin
			if (sub == `SUB_OVERRIDE && region >= `RGN_AI && region <= `RGN_BO) begin
				ack = 1'b1;
				if (region == `RGN_BO) begin
					kind = `KIND_BO_SET;
				end else if (region == `RGN_AO) begin
					kind = `KIND_AO_SET;
				end
			end else if (sub == `SUB_RELEASE && region != 4'h0 && region <= `RGN_INT_HI) begin
				ack = 1'b1;
			end
			if (ack) begin
				err = `ERR_NONE;
			end
		end
		default: begin
			ack = 1'b0;
		end
		endcase
	end
endmodule // cmd_classify

// File: hw/bas_point_command_handler.v
// Point command handler: request decode, point mapping and register port
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "bas_point_defs.vh"
module bas_point_command_handler #(
	parameter BAUD_DIV = `CLK_HZ / `BAUD_RATE,
	parameter N_TERM = 6
) (
	input wire mclk, // System clock, 250 MHz
	input wire sys_rst, // Asynchronous reset, active high
	input wire req_valid, // Decoded request present
	input wire [3:0] req_cmd, // Command code
	input wire [3:0] req_sub, // Sub-command code
	input wire [3:0] req_region, // Point region
	input wire [7:0] req_npa, // Point index
	input wire [7:0] req_attr, // Attribute number
	input wire [31:0] req_data, // Value carried by the request
	input wire [15:0] model_code_monitor_a, // Model monitor value a
	input wire [15:0] model_code_monitor_b, // Model monitor value b
	input wire [15:0] model_code_monitor_c, // Model monitor value c
	input wire [15:0] cumulative_runtime_monitor, // Run-time monitor
	input wire inverter_running, // Inverter in operation
	input wire [7:0] reg_addr, // Register byte address
	input wire [31:0] reg_wdata, // Register write data
	input wire reg_wr, // Register write strobe
	input wire reg_rd, // Register read strobe
	output reg [31:0] reg_rdata_q, // Register read data
	output reg rsp_valid_q, // Answer pulse
	output reg rsp_ack_q, // ACK when high, NAK when low
	output reg [7:0] rsp_err_q, // NAK error code
	output reg [31:0] rsp_data_q, // Answer value
	output reg rsp_change_q, // Poll answer carries pending changes
	output reg [79:0] stat_model_q, // Status reply model identifier
	output reg [15:0] stat_days_q, // Status reply days in service
	output reg [31:0] stat_dev_status_q, // Status reply device status
	output reg [15:0] run_command_word_q, // Run-command word
	output reg [15:0] universal_output_word_q, // Universal-output word as commanded
	output reg [15:0] univ_out_active_q, // Universal outputs that take effect
	output reg data_protect_setting_q, // Data-protection setting
	output reg [7:0] station_addr_q, // Station address
	output reg [15:0] fc_read_num_q, // Function-code number to read
	output reg [15:0] fc_write_num_q, // Function-code number to write
	output reg fc_group_ok_q, // Read group is a defined group
	output reg fc_write_stb_q, // Function-code data write pulse
	output reg [31:0] fc_write_data_q, // Function-code data
	output reg baud_tick_q // One-cycle bit-rate enable
);
	localparam DIV_W = 16;
	localparam integer DIV_LAST_I = BAUD_DIV - 1;
	localparam [DIV_W-1:0] DIV_LAST = DIV_LAST_I[DIV_W-1:0];

	wire cls_ack;
	wire [7:0] cls_err;
	wire [2:0] cls_kind;
	wire [31:0] lim_rdata;
	wire [5:0] req_lim_addr;
	wire [5:0] s1_lim_addr;
	wire lim_wr;
	reg s1_valid_q;
	reg s1_ack_q;
	reg [7:0] s1_err_q;
	reg [2:0] s1_kind_q;
	reg [7:0] s1_npa_q;
	reg [7:0] s1_attr_q;
	reg [31:0] s1_data_q;
	reg pending_q;
	reg [DIV_W-1:0] baud_cnt_q;
	reg [7:0] term_fn_q [0:N_TERM-1];
	reg [15:0] univ_mask_d;
	reg [3:0] bo_bit;
	integer i;
	integer j;
	integer k;

	// Defined parameter groups; reserved and unlisted codes are refused
	function grp_ok;
		input [7:0] g;
		begin
			case (g)
			8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0a, 8'h0d, 8'h0e,
			8'h0f, 8'h10, 8'h11, 8'h12, 8'h14, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1d,
			8'h1e, 8'h20, 8'h24, 8'h25, 8'h27, 8'h28, 8'h29: grp_ok = 1'b1;
			default: grp_ok = 1'b0;
			endcase
		end
	endfunction

	cmd_classify u_cls (
		.cmd(req_cmd),
		.sub(req_sub),
		.region(req_region),
		.attr(req_attr),
		.ack(cls_ack),
		.err(cls_err),
		.kind(cls_kind)
	);

	// Limit slot: point index in the high bits, attribute offset in the low;
	// attribute eight lands on offset zero, so no subtraction is needed
	assign req_lim_addr = {req_npa[2:0], req_attr[2:0]};
	assign s1_lim_addr = {s1_npa_q[2:0], s1_attr_q[2:0]};
	assign lim_wr = s1_valid_q && s1_ack_q && (s1_kind_q == `KIND_LIMIT_WR);

	ai_limit_mem #(
		.DW(32),
		.AW(6)
	) u_mem (
		.mclk(mclk),
		.wr_en(lim_wr),
		.wr_addr(s1_lim_addr),
		.wr_data(s1_data_q),
		.rd_addr(req_lim_addr),
		.rd_data_q(lim_rdata)
	);

	// Stage one holds the decision while the limit memory is read
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_valid_q <= 1'b0;
			s1_ack_q <= 1'b0;
			s1_err_q <= `ERR_NONE;
			s1_kind_q <= `KIND_NONE;
			s1_npa_q <= 8'h00;
			s1_attr_q <= 8'h00;
			s1_data_q <= 32'h00000000;
		end else begin
			s1_valid_q <= req_valid;
			s1_ack_q <= cls_ack;
			s1_err_q <= cls_err;
			s1_kind_q <= cls_kind;
			s1_npa_q <= req_npa;
			s1_attr_q <= req_attr;
			s1_data_q <= req_data;
		end
	end

	// Answer stage; answers arrive two cycles after the request
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rsp_valid_q <= 1'b0;
			rsp_ack_q <= 1'b0;
			rsp_err_q <= `ERR_NONE;
			rsp_data_q <= 32'h00000000;
			rsp_change_q <= 1'b0;
			stat_model_q <= 80'h0;
			stat_days_q <= 16'h0000;
			stat_dev_status_q <= 32'h00000000;
		end else begin
			rsp_valid_q <= s1_valid_q;
			rsp_ack_q <= s1_ack_q;
			rsp_err_q <= s1_err_q;
			rsp_data_q <= 32'h00000000;
			rsp_change_q <= 1'b0;
			if (s1_valid_q && s1_ack_q) begin
				case (s1_kind_q)
				`KIND_LIMIT_RD: begin
					rsp_data_q <= lim_rdata;
				end
				`KIND_POLL: begin
					rsp_change_q <= pending_q;
				end
				`KIND_STATUS: begin
					stat_model_q <= {model_code_monitor_a, model_code_monitor_b,
						model_code_monitor_c, `ASCII_0000};
					stat_days_q <= cumulative_runtime_monitor;
					stat_dev_status_q <= `ASCII_0000;
				end
				default: begin
					rsp_data_q <= 32'h00000000;
				end
				endcase
			end
		end
	end

	// Pending change flag: a new change in the poll cycle wins over the clear
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pending_q <= 1'b0;
		end else if (s1_valid_q && s1_ack_q && s1_kind_q == `KIND_BO_SET) begin
			pending_q <= 1'b1;
		end else if (s1_valid_q && s1_ack_q && s1_kind_q == `KIND_POLL) begin
			pending_q <= 1'b0;
		end
	end

	// Bit index inside the run-command word for points one to nine
	always @* begin
		bo_bit = s1_npa_q[3:0] - 4'h1;
	end

	// Binary-output points, protection bit and register writes
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			run_command_word_q <= 16'h0000;
			universal_output_word_q <= 16'h0000;
			data_protect_setting_q <= 1'b0;
			station_addr_q <= `STATION_RST;
			for (i = 0; i < N_TERM; i = i + 1) begin
				term_fn_q[i] <= 8'h00;
			end
		end else begin
			if (s1_valid_q && s1_ack_q && s1_kind_q == `KIND_BO_SET) begin
				if (s1_npa_q != 8'h00 && s1_npa_q <= `BO_RUN_LAST) begin
					run_command_word_q[bo_bit] <= s1_data_q[0];
				end else if (s1_npa_q == `BO_RESET) begin
					run_command_word_q[`RUN_RESET_BIT] <= s1_data_q[0];
				end else if (s1_npa_q >= `BO_UNIV_FIRST && s1_npa_q <= `BO_UNIV_LAST) begin
					universal_output_word_q[s1_npa_q[3:0] - 4'he] <= s1_data_q[0];
				end else if (s1_npa_q == `BO_RELAY) begin
					universal_output_word_q[`UNIV_RELAY_BIT] <= s1_data_q[0];
				end else if (s1_npa_q == `BO_PROTECT) begin
					data_protect_setting_q <= s1_data_q[0];
				end
			end
			if (reg_wr) begin
				if (reg_addr == `ADR_PROTECT) begin
					data_protect_setting_q <= reg_wdata[0];
				end else if (reg_addr == `ADR_STATION) begin
					if (!inverter_running) begin
						station_addr_q <= reg_wdata[7:0];
					end
				end else begin
					for (i = 0; i < N_TERM; i = i + 1) begin
						if (reg_addr == `ADR_TERM_BASE + 8'h04 * i[7:0]) begin
							term_fn_q[i] <= reg_wdata[7:0];
						end
					end
				end
			end
		end
	end

	// Enable mask: one terminal function setting per universal output bit
	always @* begin
		univ_mask_d = 16'h0000;
		for (j = 0; j < N_TERM - 1; j = j + 1) begin
			univ_mask_d[j] = (term_fn_q[j] == `TERM_FN_ACTIVE);
		end
		univ_mask_d[`UNIV_RELAY_BIT] = (term_fn_q[N_TERM-1] == `TERM_FN_ACTIVE);
	end

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			univ_out_active_q <= 16'h0000;
		end else begin
			univ_out_active_q <= universal_output_word_q & univ_mask_d;
		end
	end

	// Function-code number and data written through analog-output points
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			fc_read_num_q <= 16'h0000;
			fc_write_num_q <= 16'h0000;
			fc_group_ok_q <= 1'b0;
			fc_write_stb_q <= 1'b0;
			fc_write_data_q <= 32'h00000000;
		end else begin
			fc_write_stb_q <= 1'b0;
			fc_group_ok_q <= grp_ok(fc_read_num_q[15:8]);
			if (s1_valid_q && s1_ack_q && s1_kind_q == `KIND_AO_SET) begin
				if (s1_npa_q == `AO_FC_READ) begin
					fc_read_num_q <= s1_data_q[15:0];
				end else if (s1_npa_q == `AO_FC_WRITE) begin
					fc_write_num_q <= s1_data_q[15:0];
				end else if (s1_npa_q == `AO_FC_DATA) begin
					fc_write_stb_q <= grp_ok(fc_write_num_q[15:8]);
					fc_write_data_q <= s1_data_q;
				end
			end
		end
	end

	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			baud_cnt_q <= {DIV_W{1'b0}};
			baud_tick_q <= 1'b0;
		end else begin
			baud_tick_q <= (baud_cnt_q == DIV_LAST);
			if (baud_cnt_q == DIV_LAST) begin
				baud_cnt_q <= {DIV_W{1'b0}};
			end else begin
				baud_cnt_q <= baud_cnt_q + 16'h0001;
			end
		end
	end

	// Register read port; unmapped addresses read zero
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata_q <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata_q <= 32'h00000000;
			if (reg_addr == `ADR_RUN_WORD) begin
				reg_rdata_q <= {16'h0000, run_command_word_q};
			end else if (reg_addr == `ADR_UNIV_WORD) begin
				reg_rdata_q <= {16'h0000, universal_output_word_q};
			end else if (reg_addr == `ADR_PROTECT) begin
				reg_rdata_q <= {31'h0, data_protect_setting_q};
			end else if (reg_addr == `ADR_STATION) begin
				reg_rdata_q <= {24'h000000, station_addr_q};
			end else if (reg_addr == `ADR_FC_READ) begin
				reg_rdata_q <= {16'h0000, fc_read_num_q};
			end else if (reg_addr == `ADR_STATE) begin
				reg_rdata_q <= {29'h0, fc_group_ok_q, pending_q, inverter_running};
			end else begin
				for (k = 0; k < N_TERM; k = k + 1) begin
					if (reg_addr == `ADR_TERM_BASE + 8'h04 * k[7:0]) begin
						reg_rdata_q <= {24'h000000, term_fn_q[k]};
					end
				end
			end
		end
	end
endmodule // bas_point_command_handler

// File: testbench/bas_controller_model.sv
// Supervisory controller model that hands decoded requests to the handler
`timescale 1ns/1ps
module bas_controller_model (
	input wire mclk, // System clock
	output reg req_valid = 1'b0, // Request present
	output reg [3:0] req_cmd = 4'h0, // Command code
	output reg [3:0] req_sub = 4'h0, // Sub-command code
	output reg [3:0] req_region = 4'h0, // Point region
	output reg [7:0] req_npa = 8'h00, // Point index
	output reg [7:0] req_attr = 8'h00, // Attribute number
	output reg [31:0] req_data = 32'h0 // Request value
);
	// One request held up to its taking edge; fields are scrambled afterwards
	// so a design that samples late never sees stale values by luck
	task send(input [3:0] c, s, r, input [7:0] n, a, input [31:0] d);
		begin
			@(posedge mclk);
			req_valid <= 1'b1;
			{req_cmd, req_sub, req_region, req_npa, req_attr, req_data} <= {c, s, r, n, a, d};
			@(posedge mclk);
			req_valid <= 1'b0;
			{req_cmd, req_sub, req_region, req_npa, req_attr, req_data} <= ~{c, s, r, n, a, d};
		end
	endtask
	// function-code number goes to the dedicated analog output first
	task fc_select(input [15:0] num);
		send(4'h7, 4'h2, 4'h3, 8'h0f, 8'h00, {16'h0000, num});
	endtask
endmodule // bas_controller_model

// File: testbench/bas_point_checker_asserts.sv
// Concurrent checks on the point command handler ports
`timescale 1ns/1ps
module bas_point_checker #(
	parameter BAUD_DIV = 8
) (
	input wire mclk, // Clock
	input wire sys_rst, // Reset
	input wire req_valid, // Request
	input wire [3:0] req_cmd, // Command
	input wire [3:0] req_sub, // Sub-command
	input wire [3:0] req_region, // Region
	input wire [7:0] req_npa, // Point index
	input wire [7:0] req_attr, // Attribute
	input wire [31:0] req_data, // Value
	input wire [15:0] cumulative_runtime_monitor, // Run time
	input wire inverter_running, // Running
	input wire [7:0] reg_addr, // Address
	input wire reg_wr, // Write strobe
	input wire rsp_valid_q, // Answer
	input wire rsp_ack_q, // ACK
	input wire [7:0] rsp_err_q, // Error code
	input wire [15:0] stat_days_q, // Days
	input wire [31:0] stat_dev_status_q, // Status
	input wire [15:0] run_command_word_q, // Run word
	input wire data_protect_setting_q, // Protection
	input wire [7:0] station_addr_q, // Station
	input wire baud_tick_q // Bit tick
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	wire sys_q = req_valid && req_cmd == 4'h0;
	wire bo_q = req_valid && req_cmd == 4'h7 && req_sub == 4'h2 && req_region == 4'h4;
	reg [15:0] tick_cnt_q;
	reg tick_seen_q;
	// Cycles since the last bit tick; the first tick has no reference
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tick_cnt_q <= 16'h0000;
			tick_seen_q <= 1'b0;
		end else begin
			tick_cnt_q <= baud_tick_q ? 16'h0001 : tick_cnt_q + 16'h0001;
			tick_seen_q <= tick_seen_q | baud_tick_q;
		end
	end
	a_answer_delay: assert property (req_valid |-> ##2 rsp_valid_q)
		else $error("answer not two cycles after request");
	a_nak_cmd_code: assert property (sys_q && req_sub inside {4'h1, 4'h8}
		|-> ##2 !rsp_ack_q && rsp_err_q == 8'h01) else $error("read-memory or warm start not NAK 01");
	a_ack_sync_poll: assert property (sys_q && req_sub inside {4'h0, 4'h4, 4'h5}
		|-> ##2 rsp_ack_q && rsp_err_q == 8'h00) else $error("sync or poll not ACK");
	a_ai_attr_nak: assert property (req_valid && req_cmd == 4'h1 && req_region == 4'h1
		&& req_attr inside {[8'h04:8'h07], 8'h0d, 8'h0e} |-> ##2 !rsp_ack_q && rsp_err_q == 8'h11)
		else $error("undefined analog attribute not NAK 11");
	a_status_fixed: assert property (sys_q && req_sub == 4'h9 |-> ##3
		stat_dev_status_q == 32'h30303030 && stat_days_q == $past(cumulative_runtime_monitor, 3))
		else $error("status reply fields wrong");
	a_run_point_bit: assert property (bo_q && req_npa >= 8'h01 && req_npa <= 8'h09 |-> ##3
		run_command_word_q[$past(req_npa[3:0], 3) - 4'h1] == $past(req_data[0], 3))
		else $error("run word bit not set by point");
	a_reset_point: assert property (bo_q && req_npa == 8'h0d
		|-> ##3 run_command_word_q[15] == $past(req_data[0], 3)) else $error("reset bit wrong");
	a_protect_point: assert property (bo_q && req_npa == 8'h14
		|-> ##3 data_protect_setting_q == $past(req_data[0], 3)) else $error("protection wrong");
	a_station_lock: assert property (inverter_running && reg_wr && reg_addr == 8'h0c
		|=> $stable(station_addr_q)) else $error("station changed while running");
	a_bit_period: assert property (baud_tick_q && tick_seen_q |-> tick_cnt_q == BAUD_DIV)
		else $error("bit tick spacing wrong");
endmodule // bas_point_checker
bind bas_point_command_handler bas_point_checker #(.BAUD_DIV(BAUD_DIV)) u_bas_point_checker (
	.mclk, .sys_rst, .req_valid, .req_cmd, .req_sub, .req_region, .req_npa, .req_attr, .req_data,
	.cumulative_runtime_monitor, .inverter_running, .reg_addr, .reg_wr, .rsp_valid_q, .rsp_ack_q,
	.rsp_err_q, .stat_days_q, .stat_dev_status_q, .run_command_word_q, .data_protect_setting_q,
	.station_addr_q, .baud_tick_q
);

// File: testbench/bas_point_command_handler_tb.sv
// Self-checking bench for the point command handler
`timescale 1ns/1ps
module bas_point_command_handler_tb;
	localparam DIV = 8;
	reg mclk = 1'b0;
	reg sys_rst = 1'b1;
	reg [15:0] model_code_monitor_a = 16'h1234, model_code_monitor_b = 16'h5678;
	reg [15:0] model_code_monitor_c = 16'h9abc, cumulative_runtime_monitor = 16'h0102;
	reg inverter_running = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h0, rd, dat;
	reg chg;
	wire req_valid, rsp_valid_q, rsp_ack_q, rsp_change_q, data_protect_setting_q;
	wire fc_group_ok_q, fc_write_stb_q, baud_tick_q;
	wire [3:0] req_cmd, req_sub, req_region;
	wire [7:0] req_npa, req_attr, rsp_err_q, station_addr_q;
	wire [31:0] req_data, reg_rdata_q, rsp_data_q, stat_dev_status_q, fc_write_data_q;
	wire [79:0] stat_model_q;
	wire [15:0] stat_days_q, run_command_word_q, universal_output_word_q, univ_out_active_q;
	wire [15:0] fc_read_num_q, fc_write_num_q;
	integer errors = 0, total_checks = 0;
	bas_point_command_handler #(.BAUD_DIV(DIV)) u_bas_point_command_handler (.*);
	bas_controller_model u_bas_controller_model (.*);
	// Clock, watchdog and the main sequence
	initial forever #2 mclk = ~mclk;
	initial begin
		#100000;
		errors = errors + 1;
		stop_test;
	end
	initial begin
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		t_station;
		t_sys;
		t_status;
		t_ai;
		t_bo;
		t_poll;
		t_fc;
		t_baud;
		stop_test;
	end
	task stop_test;
		begin
			$display("checks %0d errors %0d", total_checks, errors);
			if (errors == 0 && total_checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task chk(input [8*10:1] nm, input [79:0] exp, input [79:0] got);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("[ERR] %0s exp %h got %h", nm, exp, got);
			end
		end
	endtask
	// Waits a bounded time for the answer pulse and judges it in its cycle
	task chk_rsp(input k, input [7:0] e);
		integer i;
		begin
			#1;
			for (i = 0; i < 4 && rsp_valid_q !== 1'b1; i = i + 1) begin
				@(posedge mclk);
				#1;
			end
			chg = rsp_change_q;
			dat = rsp_data_q;
			chk("answer", {1'b1, k, e}, {rsp_valid_q, rsp_ack_q, rsp_err_q});
		end
	endtask
	task ask(input [3:0] c, s, r, input [7:0] n, a, input [31:0] d, input k, input [7:0] e);
		begin
			u_bas_controller_model.send(c, s, r, n, a, d);
			chk_rsp(k, e);
		end
	endtask
	task bus_wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge mclk);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge mclk);
			reg_wr <= 1'b0;
		end
	endtask
	// Read data stand from the edge after the strobe and hold until the next read strobe
	task bus_rd(input [7:0] a);
		begin
			@(posedge mclk);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge mclk);
			reg_rd <= 1'b0;
			#1 rd = reg_rdata_q;
		end
	endtask
	task t_station;
		begin
			bus_rd(8'h0c);
			chk("station", 32'h01, rd);
			bus_wr(8'h0c, 32'h22);
			@(posedge mclk) inverter_running <= 1'b1;
			bus_wr(8'h0c, 32'h33);
			bus_rd(8'h0c);
			chk("station", 32'h22, rd);
			@(posedge mclk) inverter_running <= 1'b0;
			bus_rd(8'hfc);
			chk("unmapped", 32'h0, rd);
		end
	endtask
	task t_sys;
		integer i;
		reg [27:0] tbl;
		reg [3:0] s;
		reg k;
		begin
			tbl = 28'h2984510;
			for (i = 0; i < 7; i = i + 1) begin
				s = tbl[4*i +: 4];
				k = s == 4'h0 || s == 4'h4 || s == 4'h5 || s == 4'h9;
				ask(4'h0, s, 4'h0, 8'h00, 8'h00, 32'h0, k, k ? 8'h00 : 8'h01);
			end
		end
	endtask
	task t_status;
		begin
			ask(4'h0, 4'h9, 4'h0, 8'h00, 8'h00, 32'h0, 1'b1, 8'h00);
			chk("model", {48'h123456789abc, 32'h30303030}, stat_model_q);
			chk("days", 16'h0102, stat_days_q);
			chk("status", 32'h30303030, stat_dev_status_q);
		end
	endtask
	task t_ai;
		integer a;
		reg k;
		begin
			for (a = 8; a <= 12; a = a + 1)
				ask(4'h2, 4'h0, 4'h1, 8'h02, a[7:0], 32'h41200000 + a, 1'b1, 8'h00);
			ask(4'h2, 4'h0, 4'h1, 8'h03, 8'h08, 32'h0, 1'b1, 8'h00);
			for (a = 0; a <= 14; a = a + 1) begin
				k = (a >= 1 && a <= 3) || (a >= 8 && a <= 12);
				ask(4'h1, 4'h0, 4'h1, 8'h02, a[7:0], 32'h0, k, k ? 8'h00 : 8'h11);
				if (a >= 8 && a <= 12)
					chk("limit", 32'h41200000 + a, dat);
			end
			for (a = 0; a <= 4; a = a + 1) begin
				k = a == 1 || a == 2;
				ask(4'h1, 4'h0, 4'h2, 8'h05, a[7:0], 32'h0, k, k ? 8'h00 : 8'h11);
			end
			ask(4'h1, 4'h0, 4'h5, 8'h00, 8'h01, 32'h0, 1'b0, 8'h01);
		end
	endtask
	task t_bo;
		integer n;
		begin
			for (n = 1; n <= 20; n = n + 1)
				ask(4'h7, 4'h2, 4'h4, n[7:0], 8'h00, 32'h1, 1'b1, 8'h00);
			bus_rd(8'h00);
			chk("run word", 32'h81ff, rd);
			bus_rd(8'h04);
			chk("univ word", 32'h011f, rd);
			chk("protect", 1'b1, data_protect_setting_q);
			bus_wr(8'h18, 32'h1b);
			bus_wr(8'h1c, 32'h1a);
			bus_wr(8'h2c, 32'h1b);
			repeat (3) @(posedge mclk);
			#1 chk("active", 16'h0101, univ_out_active_q);
			ask(4'h7, 4'h2, 4'h4, 8'h01, 8'h00, 32'h0, 1'b1, 8'h00);
			ask(4'h7, 4'h2, 4'h4, 8'h14, 8'h00, 32'h0, 1'b1, 8'h00);
			chk("run word", 16'h81fe, run_command_word_q);
			chk("protect", 1'b0, data_protect_setting_q);
		end
	endtask
	task t_poll;
		begin
			ask(4'h7, 4'h2, 4'h4, 8'h0b, 8'h00, 32'h1, 1'b1, 8'h00);
			chk("run word", 16'h81fe, run_command_word_q);
			ask(4'h0, 4'h5, 4'h0, 8'h00, 8'h00, 32'h0, 1'b1, 8'h00);
			chk("change", 1'b1, chg);
			ask(4'h0, 4'h4, 4'h0, 8'h00, 8'h00, 32'h0, 1'b1, 8'h00);
			chk("change", 1'b0, chg);
		end
	endtask
	task t_fc;
		integer i;
		reg [63:0] grp;
		begin
			grp = 64'h0c0b09000f040302;
			for (i = 0; i < 8; i = i + 1) begin
				u_bas_controller_model.fc_select({grp[8*i +: 8], 8'h05});
				chk_rsp(1'b1, 8'h00);
				chk("fc number", {grp[8*i +: 8], 8'h05}, fc_read_num_q);
				repeat (2) @(posedge mclk);
				#1 chk("fc group", i < 4, fc_group_ok_q);
			end
			// Data write goes out only for a defined write group
			ask(4'h7, 4'h2, 4'h3, 8'h10, 8'h00, 32'h0405, 1'b1, 8'h00);
			chk("fc wr num", 16'h0405, fc_write_num_q);
			ask(4'h7, 4'h2, 4'h3, 8'h11, 8'h00, 32'h3f800000, 1'b1, 8'h00);
			chk("fc wr stb", 1'b1, fc_write_stb_q);
			chk("fc wr data", 32'h3f800000, fc_write_data_q);
			ask(4'h7, 4'h2, 4'h3, 8'h10, 8'h00, 32'h0905, 1'b1, 8'h00);
			ask(4'h7, 4'h2, 4'h3, 8'h11, 8'h00, 32'h1, 1'b1, 8'h00);
			chk("fc wr stb", 1'b0, fc_write_stb_q);
		end
	endtask
	task t_baud;
		integer i, a, b;
		begin
			a = -1;
			b = -1;
			for (i = 0; i < 4 * DIV; i = i + 1) begin
				@(posedge mclk);
				#1;
				if (baud_tick_q === 1'b1) begin
					b = a;
					a = i;
				end
			end
			chk("bit period", DIV, a - b);
		end
	endtask
endmodule // bas_point_command_handler_tb
